/* logic/pwe_control.sv */
// Power mode, wake event status, event pin and go-sleep sequencer
//
// How it works
// [RQ1] A host queue unit wake-up frame sets status bit 5; a one clears it.
// [RQ2] A remote-wake packet on either port sets bit 4; a one clears it.
// [RQ3] Link-up on either port sets status bit 3; a one clears it.
// [RQ4] Line energy on either port sets status bit 2; a one clears it.
// [RQ5] Mode 00 normal, 01 energy detect, 10 soft power-down; resets to 00.
// [RQ6] Enable bit 4 set makes the event pin active high, clear active low.
// [RQ7] Enable bit 3 lets a wake-up frame drive the event pin.
// [RQ8] Enable bit 2 lets a remote-wake packet drive the event pin.
// [RQ9] Enable bit 1 lets a link-up drive the event pin.
// [RQ10] Enable bit 0 lets line energy drive the event pin.
// [RQ11] Energy detect mode sleeps after go-sleep times 20 ms with no energy.
// [RQ12] The go-sleep field resets to 0x8E.
// [RQ13] The ten upper bits of the mode and status register read as zero.
// [RQ14] The pin is active at its polarity while an enabled status bit is set.
`timescale 1ns/1ps
module pwe_control #(
    parameter int UNIT_CYCLES = pwe_pkg::UNIT_CYCLES_I
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pwe_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pwe_pkg::DATA_W-1:0] reg_wdata,
    output logic [pwe_pkg::DATA_W-1:0] reg_rdata,
    input wire logic wake_frame_det,
    input wire logic remote_wake_det,
    input wire logic link_up_det,
    input wire logic energy_det,
    output logic wake_event_output,
    output pwe_pkg::pwe_mode_e power_mode,
    output logic low_power
);
    import pwe_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_EVT-1:0] sync1;
        logic [NUM_EVT-1:0] sync2;
        logic [NUM_EVT-1:0] status;
        logic [EN_REG_W-1:0] enable;
        pwe_mode_e mode;
        logic [7:0] dwell;
        logic [7:0] units;
        pwe_state_e seq;
        logic [DATA_W-1:0] rdata;
        logic pin;
    } pwe_ctl_s;

    pwe_ctl_s st;
    pwe_ctl_s next_st;
    pwe_tick_if tk();
    logic [NUM_EVT-1:0] raw_evt;
    logic [NUM_EVT-1:0] w1c;
    logic pin_active;

    // Address decode used by both write and read paths
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ------------------------------------------------------------------
    // Divider for the 20 ms dwell unit
    // ------------------------------------------------------------------
    pwe_tick_gen #(.UNIT_CYCLES(UNIT_CYCLES)) u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tk(tk)
    );

    assign raw_evt = {wake_frame_det, remote_wake_det, link_up_det,
                      energy_det};
    assign w1c = (reg_wr && hit(reg_addr, OFS_MODE_STATUS))
                 ? reg_wdata[EVT_HI:EVT_LO] : '0;
    // Any enabled sticky event makes the pin active
    assign pin_active = |(st.status & st.enable[EN_HI:0]); // [RQ14]
    assign tk.clear = (st.seq != PWE_ST_WAIT) || st.sync2[0];

    // Next-state logic for registers, events and sequencer
    always_comb begin
        next_st = st;
        next_st.sync1 = raw_evt;
        next_st.sync2 = st.sync1;
        // Sticky events; a new event wins over a same-cycle clear
        for (int i = 0; i < NUM_EVT; i++) begin // [RQ1][RQ2][RQ3][RQ4]
            next_st.status[i] = st.sync2[i] | (st.status[i] & ~w1c[i]);
        end
        if (reg_wr && hit(reg_addr, OFS_MODE_STATUS)) begin
            next_st.mode = pwe_mode_e'(reg_wdata[MODE_W-1:0]); // [RQ5]
        end
        if (reg_wr && hit(reg_addr, OFS_EVENT_ENABLE)) begin
            next_st.enable = reg_wdata[EN_REG_W-1:0]; // [RQ7][RQ8][RQ9][RQ10]
        end
        if (reg_wr && hit(reg_addr, OFS_DWELL)) begin
            next_st.dwell = reg_wdata[7:0]; // [RQ11]
        end
        // Read data registered, reserved bits zero
        next_st.rdata = RD_UNMAPPED;
        if (reg_rd) begin
            if (hit(reg_addr, OFS_MODE_STATUS)) begin
                next_st.rdata = {10'h000, st.status, st.mode}; // [RQ13]
            end else if (hit(reg_addr, OFS_EVENT_ENABLE)) begin
                next_st.rdata = {11'h000, st.enable};
            end else if (hit(reg_addr, OFS_DWELL)) begin
                next_st.rdata = {8'h00, st.dwell};
            end
        end
        // Pin level at the selected polarity
        next_st.pin = st.enable[EN_POLARITY] ? pin_active // [RQ6] [RQ14]
                                             : ~pin_active;
        // Go-sleep sequencer
        unique case (st.seq)
            PWE_ST_AWAKE: begin
                next_st.units = '0;
                if (st.mode == PWE_MODE_ENERGY && !st.sync2[0]) begin
                    next_st.seq = PWE_ST_WAIT;
                end
            end
            PWE_ST_WAIT: begin
                if (st.mode != PWE_MODE_ENERGY || st.sync2[0]) begin
                    next_st.seq = PWE_ST_AWAKE; // [RQ11]
                    next_st.units = '0;
                end else if (st.units >= st.dwell) begin
                    next_st.seq = PWE_ST_LOW; // [RQ11]
                end else if (tk.tick) begin
                    next_st.units = st.units + 8'h01;
                end
            end
            PWE_ST_LOW: begin
                if (st.mode != PWE_MODE_ENERGY || st.sync2[0]) begin
                    next_st.seq = PWE_ST_AWAKE;
                end
            end
            default: begin
                next_st.seq = PWE_ST_AWAKE;
            end
        endcase
    end

    // State register with its reset values
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st.sync1 <= '0;
            st.sync2 <= '0;
            st.status <= STATUS_RESET;
            st.enable <= ENABLE_RESET;
            st.mode <= PWE_MODE_NORMAL; // [RQ5]
            st.dwell <= DWELL_RESET; // [RQ12]
            st.units <= '0;
            st.seq <= PWE_ST_AWAKE;
            st.rdata <= '0;
            st.pin <= 1'b1; // Inactive for the active-low default
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign wake_event_output = st.pin;
    assign power_mode = st.mode;
    assign low_power = (st.seq == PWE_ST_LOW);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_rq1;
        @(posedge core_clk) disable iff (!rst_n)
        st.sync2[3] |=> st.status[3];
    endproperty
    a_rq1: assert property (p_rq1) // [RQ1]
        else $error("frame status not set");

    property p_rq2;
        @(posedge core_clk) disable iff (!rst_n)
        st.status[2] && !w1c[2] |=> st.status[2];
    endproperty
    a_rq2: assert property (p_rq2) // [RQ2]
        else $error("remote status lost");

    // A link-up seen in the clearing cycle still sets the bit
    property p_rq3_set;
        @(posedge core_clk) disable iff (!rst_n)
        st.sync2[1] |=> st.status[1];
    endproperty
    a_rq3_set: assert property (p_rq3_set) // [RQ3]
        else $error("link status not set");

    property p_rq3;
        @(posedge core_clk) disable iff (!rst_n)
        w1c[1] && !st.sync2[1] |=> !st.status[1];
    endproperty
    a_rq3: assert property (p_rq3) // [RQ3]
        else $error("link status not cleared");

    property p_rq4;
        @(posedge core_clk) disable iff (!rst_n)
        energy_det ##2 1'b1 |=> st.status[0];
    endproperty
    a_rq4: assert property (p_rq4) // [RQ4]
        else $error("energy status not set");

    property p_rq5;
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr && hit(reg_addr, OFS_MODE_STATUS)
        |=> power_mode == $past(reg_wdata[1:0]);
    endproperty
    a_rq5: assert property (p_rq5) // [RQ5]
        else $error("mode not written");

    // Idle level follows the polarity in force when it was launched
    property p_rq6;
        @(posedge core_clk) disable iff (!rst_n)
        !pin_active && $stable(st.enable)
        |=> wake_event_output == ~$past(st.enable[EN_POLARITY]);
    endproperty
    a_rq6: assert property (p_rq6) // [RQ6]
        else $error("idle pin level wrong");

    property p_rq14;
        @(posedge core_clk) disable iff (!rst_n)
        pin_active && st.enable[EN_POLARITY] |=> wake_event_output;
    endproperty
    a_rq14: assert property (p_rq14) // [RQ14]
        else $error("pin not asserted");

    // Active-high pin drops once no enabled bit is left
    property p_rq14_off;
        @(posedge core_clk) disable iff (!rst_n)
        !pin_active && st.enable[EN_POLARITY] |=> !wake_event_output;
    endproperty
    a_rq14_off: assert property (p_rq14_off) // [RQ14]
        else $error("pin not released");

    property p_rq7;
        @(posedge core_clk) disable iff (!rst_n)
        st.status == 4'h8 && !st.enable[3] && !st.enable[EN_POLARITY]
        |=> wake_event_output;
    endproperty
    a_rq7: assert property (p_rq7) // [RQ7]
        else $error("masked frame drove pin");

    // Masked remote-wake status leaves the pin idle
    property p_rq8;
        @(posedge core_clk) disable iff (!rst_n)
        st.status == 4'h4 && !st.enable[2] && !st.enable[EN_POLARITY]
        |=> wake_event_output;
    endproperty
    a_rq8: assert property (p_rq8) // [RQ8]
        else $error("masked remote wake drove pin");

    // Masked link-up status leaves the pin idle
    property p_rq9;
        @(posedge core_clk) disable iff (!rst_n)
        st.status == 4'h2 && !st.enable[1] && !st.enable[EN_POLARITY]
        |=> wake_event_output;
    endproperty
    a_rq9: assert property (p_rq9) // [RQ9]
        else $error("masked link-up drove pin");

    // Masked energy status leaves the pin idle
    property p_rq10;
        @(posedge core_clk) disable iff (!rst_n)
        st.status == 4'h1 && !st.enable[0] && !st.enable[EN_POLARITY]
        |=> wake_event_output;
    endproperty
    a_rq10: assert property (p_rq10) // [RQ10]
        else $error("masked energy drove pin");

    // Low power is entered only from a full quiet dwell in energy mode
    property p_rq11;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(low_power) |-> $past(st.mode) == PWE_MODE_ENERGY
                             && $past(st.units) >= $past(st.dwell);
    endproperty
    a_rq11: assert property (p_rq11) // [RQ11]
        else $error("sleep too early");

    // The dwell count moves only on a unit tick
    property p_rq11_hold;
        @(posedge core_clk) disable iff (!rst_n)
        st.seq == PWE_ST_WAIT && !tk.tick
        |=> $stable(st.units) || st.seq != PWE_ST_WAIT;
    endproperty
    a_rq11_hold: assert property (p_rq11_hold) // [RQ11]
        else $error("dwell count moved without tick");

    // Energy on the line always ends low power
    property p_rq11_wake;
        @(posedge core_clk) disable iff (!rst_n)
        st.sync2[0] |=> !low_power;
    endproperty
    a_rq11_wake: assert property (p_rq11_wake) // [RQ11]
        else $error("energy did not wake");

    // Registers leave reset at their reset values
    property p_rq12;
        @(posedge core_clk)
        $rose(rst_n) |-> st.dwell == DWELL_RESET
                         && st.mode == PWE_MODE_NORMAL
                         && st.enable == ENABLE_RESET;
    endproperty
    a_rq12: assert property (p_rq12) // [RQ12]
        else $error("reset value wrong");

    property p_rq13;
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && hit(reg_addr, OFS_MODE_STATUS) |=> reg_rdata[15:6] == 10'h000;
    endproperty
    a_rq13: assert property (p_rq13) // [RQ13]
        else $error("reserved bits set");
endmodule : pwe_control

/* pkg/pwe_pkg.sv */
// Constants, register map and types of the power and wake event control
package pwe_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] OFS_MODE_STATUS = 8'h32;
    localparam logic [7:0] OFS_EVENT_ENABLE = 8'h34;
    localparam logic [7:0] OFS_DWELL = 8'h36;
    localparam logic [15:0] RD_UNMAPPED = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_WAKE_FRAME = 5;
    localparam int BIT_REMOTE_WAKE = 4;
    localparam int BIT_LINK_UP = 3;
    localparam int BIT_ENERGY = 2;
    localparam int EVT_LO = 2;
    localparam int EVT_HI = 5;
    localparam int EN_POLARITY = 4;
    localparam int EN_HI = 3;
    localparam int NUM_EVT = 4;
    localparam int EN_REG_W = 5;
    localparam int MODE_W = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DWELL_RESET = 8'h8E;
    localparam logic [4:0] ENABLE_RESET = 5'h00;
    localparam logic [3:0] STATUS_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int DWELL_UNIT_MS = 20;
    localparam int UNIT_CYCLES_I = CLK_HZ / 1000 * DWELL_UNIT_MS;
    localparam int TICK_W = 20;

    // Power mode codes
    typedef enum logic [1:0] {
        PWE_MODE_NORMAL = 2'h0,
        PWE_MODE_ENERGY = 2'h1,
        PWE_MODE_SOFT_PD = 2'h2,
        PWE_MODE_RSVD = 2'h3
    } pwe_mode_e;

    // Sleep sequencer states
    typedef enum logic [2:0] {
        PWE_ST_AWAKE = 3'h1,
        PWE_ST_WAIT = 3'h2,
        PWE_ST_LOW = 3'h4
    } pwe_state_e;
endpackage : pwe_pkg

/* pkg/pwe_tick_if.sv */
// Interface carrying the dwell unit tick between the sequencer modules
`timescale 1ns/1ps
interface pwe_tick_if;
    logic clear;
    logic tick;
    modport src (input clear, output tick);
    modport snk (output clear, input tick);
endinterface : pwe_tick_if

/* logic/pwe_tick_gen.sv */
// Divider that pulses once per dwell unit while the sequencer lets it run
`timescale 1ns/1ps
module pwe_tick_gen #(
    parameter int UNIT_CYCLES = pwe_pkg::UNIT_CYCLES_I
) (
    input wire logic core_clk,
    input wire logic rst_n,
    pwe_tick_if.src tk
);
    import pwe_pkg::*;

    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic tick;
    } pwe_tick_s;

    pwe_tick_s st;
    pwe_tick_s next_st;
    localparam logic [TICK_W-1:0] LAST = TICK_W'(UNIT_CYCLES - 1);

    // Count cycles, restart on clear, pulse on wrap
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (tk.clear) begin
            next_st.cnt = '0;
        end else if (st.cnt == LAST) begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tk.tick = st.tick;

    // No tick in the cycle right after a clear
    property p_tick_spacing;
        @(posedge core_clk) disable iff (!rst_n)
        st.tick |-> !$past(tk.clear);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("tick after clear");
endmodule : pwe_tick_gen

/* verification/pwe_host_model.sv */
// Host-side model that watches the wake event pin
`timescale 1ns/1ps
module pwe_host_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wake_event_output,
    input wire logic active_high,
    output logic wake_seen,
    output logic [7:0] wake_count
);
    // Pin at its programmed active level means a wake request
    assign wake_seen = (wake_event_output === active_high);

    // Count new wake requests as the host would service them
    logic seen_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= 1'b0;
            wake_count <= 8'h00;
        end else begin
            seen_q <= wake_seen;
            if (wake_seen && !seen_q) begin
                wake_count <= wake_count + 8'h01;
            end
        end
    end
endmodule : pwe_host_model

/* verification/power_wake_event_control_bench.sv */
// Self-checking bench of the power and wake event control
`timescale 1ns/1ps
module power_wake_event_control_bench;
    import pwe_pkg::*;
    localparam int UNIT = 10;
    logic core_clk, rst_n, reg_wr, reg_rd, pol, low_power;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, got;
    logic [3:0] det;
    logic wake_event_output, wake_seen;
    logic [7:0] wake_count;
    pwe_mode_e power_mode;
    int bad_count, samples_checked, k;

    pwe_control #(.UNIT_CYCLES(UNIT)) uut (.core_clk(core_clk),
        .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .wake_frame_det(det[3]), .remote_wake_det(det[2]),
        .link_up_det(det[1]), .energy_det(det[0]),
        .wake_event_output(wake_event_output), .power_mode(power_mode),
        .low_power(low_power));
    pwe_host_model host (.core_clk(core_clk), .rst_n(rst_n),
        .wake_event_output(wake_event_output), .active_high(pol),
        .wake_seen(wake_seen), .wake_count(wake_count));

    // Clock at 20 MHz
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] act, exp, input string what);
        samples_checked++;
        if (act !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what,
                     act, exp);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cycles

    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        cycles(1);
        reg_wr = 1'b0;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        cycles(1);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : read_reg

    task automatic pulse(input int i);
        @(posedge core_clk);
        #1;
        det[i] = 1'b1;
        cycles(2);
        det[i] = 1'b0;
        cycles(4);
    endtask : pulse

    task automatic t_reset;
        check(wake_event_output, 16'h1, "pin idle");
        write_reg(8'h38, 16'hFFFF);
        read_reg(OFS_MODE_STATUS, got);
        check(got, 16'h0000, "mode status");
        read_reg(OFS_EVENT_ENABLE, got);
        check(got, 16'h0000, "enable");
        read_reg(OFS_DWELL, got);
        check(got, 16'h008E, "dwell");
        read_reg(8'h38, got);
        check(got, RD_UNMAPPED, "unmapped");
    endtask : t_reset

    task automatic t_events;
        for (int i = 0; i < NUM_EVT; i++) begin
            pulse(i);
            read_reg(OFS_MODE_STATUS, got);
            check(got, 16'h1 << (i + 2), "status set");
            check(wake_seen, 16'h0, "pin off");
            write_reg(OFS_EVENT_ENABLE, 16'h1 << i);
            cycles(2);
            check(wake_seen, 16'h1, "pin on");
            write_reg(OFS_MODE_STATUS, 16'h0000);
            read_reg(OFS_MODE_STATUS, got);
            check(got, 16'h1 << (i + 2), "sticky");
            write_reg(OFS_MODE_STATUS, 16'h1 << (i + 2));
            cycles(2);
            read_reg(OFS_MODE_STATUS, got);
            check(got, 16'h0000, "cleared");
            check(wake_seen, 16'h0, "pin released");
        end
        check(wake_count, 16'h4, "host wakes");
    endtask : t_events

    task automatic t_polarity;
        write_reg(OFS_EVENT_ENABLE, 16'h0011);
        pol = 1'b1;
        cycles(2);
        check(wake_event_output, 16'h0, "high idle");
        pulse(0);
        check(wake_event_output, 16'h1, "high on");
        write_reg(OFS_MODE_STATUS, 16'h0004);
        cycles(2);
        check(wake_event_output, 16'h0, "high off");
        write_reg(OFS_EVENT_ENABLE, 16'h0000);
        pol = 1'b0;
    endtask : t_polarity

    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            write_reg(OFS_MODE_STATUS, 16'hFFC0 | m);
            read_reg(OFS_MODE_STATUS, got);
            check(got, m, "mode read");
            check(power_mode, m, "mode port");
        end
        write_reg(OFS_MODE_STATUS, 16'h0000);
    endtask : t_modes

    task automatic t_sleep;
        write_reg(OFS_DWELL, 16'hFF03);
        read_reg(OFS_DWELL, got);
        check(got, 16'h0003, "dwell field");
        write_reg(OFS_MODE_STATUS, 16'h0001);
        // One cycle short of three full dwell units
        cycles(3 * UNIT - 1);
        check(low_power, 16'h0, "early sleep");
        k = 0;
        while (low_power !== 1'b1 && k < 25) begin
            cycles(1);
            k++;
        end
        check(low_power, 16'h1, "sleep");
        det[0] = 1'b1;
        cycles(6);
        check(low_power, 16'h0, "energy wakes");
        det[0] = 1'b0;
        cycles(18);
        check(low_power, 16'h0, "count restart");
        write_reg(OFS_MODE_STATUS, 16'h0004);
        cycles(50);
        check(low_power, 16'h0, "normal awake");
    endtask : t_sleep

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // Watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        results();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        det = 4'h0;
        pol = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        cycles(6);
        rst_n = 1'b1;
        t_reset();
        t_events();
        t_polarity();
        t_modes();
        t_sleep();
        results();
    end
endmodule : power_wake_event_control_bench
